//--- common/xcvr_regs_pkg.sv
// Package for the transceiver control and status register bank.
// Assumes AXI4-Lite 32-bit data; each byte register sits in one aligned word.
`default_nettype none
package xcvr_regs_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  can_ctrl_index   = 8'h20;
  localparam logic [7:0]  lin_ctrl_index   = 8'h21;
  localparam logic [7:0]  status_index     = 8'h22;
  localparam logic [9:0]  can_ctrl_addr    = {can_ctrl_index, 2'b00};
  localparam logic [9:0]  lin_ctrl_addr    = {lin_ctrl_index, 2'b00};
  localparam logic [9:0]  status_addr      = {status_index, 2'b00};
  localparam int          addr_bits        = 10;

  // Field positions
  localparam int          fd_tol_pos       = 6;
  localparam int          sw_valid_pos     = 5;
  localparam int          sw_enable_pos    = 4;
  localparam int          shutdown_lsb     = 2;
  localparam int          can_mode_lsb     = 0;
  localparam int          lin_b_slope_lsb  = 6;
  localparam int          lin_b_mode_lsb   = 4;
  localparam int          lin_a_slope_lsb  = 2;
  localparam int          lin_a_mode_lsb   = 0;

  // Write masks: reserved bits ignore writes
  localparam logic [7:0]  can_pn_mask      = 8'h7f;
  localparam logic [7:0]  can_base_mask    = 8'h0f;
  localparam logic [7:0]  lin_dual_mask    = 8'hff;
  localparam logic [7:0]  lin_single_mask  = 8'h0f;

  // Reset values
  localparam logic [7:0]  can_ctrl_reset   = 8'h00;
  localparam logic [7:0]  lin_ctrl_reset   = 8'h00;

  // AXI responses
  localparam logic [1:0]  resp_okay        = 2'b00;
  localparam logic [1:0]  resp_slverr      = 2'b10;

  typedef enum logic [1:0] {
    mode_offline  = 2'b00,
    mode_active   = 2'b01,
    mode_active_b = 2'b10,
    mode_listen   = 2'b11
  } xcvr_mode_t;

  typedef enum logic [1:0] {
    slope_on      = 2'b00,
    slope_on_b    = 2'b01,
    slope_no_tout = 2'b10,
    slope_rsvd    = 2'b11
  } slope_t;

  typedef struct packed {
    logic       fd_tolerance_enable;
    logic       selective_wake_config_valid;
    logic       selective_wake_enable;
    logic [1:0] shutdown_policy;
    xcvr_mode_t can_xcvr_mode;
  } can_ctrl_t;

  typedef struct packed {
    slope_t     lin_b_slope_sel;
    xcvr_mode_t lin_b_mode;
    slope_t     lin_a_slope_sel;
    xcvr_mode_t lin_a_mode;
  } lin_ctrl_t;

  // Status inputs from the transceivers and monitors
  typedef struct packed {
    logic can_tx_ready;
    logic fd_frame_error_flag;
    logic osc_on_target;
    logic bus_silence_flag;
    logic lin_supply_fault_flag;
    logic can_supply_flag;
    logic can_tx_timeout_flag;
  } xcvr_status_in_t;

  // Decoded transceiver controls
  typedef struct packed {
    logic can_active;
    logic can_listen;
    logic can_supply_uv_enable;
    logic can_shutdown;
    logic fd_tolerance_enable;
    logic selective_wake_enable;
    logic lin_a_active;
    logic lin_a_listen;
    logic lin_a_timeout_enable;
    logic lin_b_active;
    logic lin_b_listen;
    logic lin_b_timeout_enable;
  } xcvr_ctrl_out_t;
endpackage : xcvr_regs_pkg
`default_nettype wire

//--- rtl/bus_xcvr_ctrl_status_regs.sv
// Transceiver control and status register bank with an AXI4-Lite slave.
// Assumes status inputs arrive from other clock domains or pins and are
// synchronised here; control outputs feed the CAN and LIN transceivers.
//
// Functional notes
// - Decode CAN, LIN control and status registers
// - CAN control bit 7 reserved, read-only
// - Bit 6 enables FD tolerance
// - Bit 5 marks selective-wake setup valid
// - Bit 4 enables selective wake-up
// - Policy 00 never shuts CAN down
// - Policy 01/10/11 shut down on under/over/either
// - CAN mode 00 offline, 01 active, 11 listen
// - CAN mode 10 active without supply undervoltage
// - LIN slope 10 disables dominant time-out
// - LIN mode 00 offline, 01/10 active, 11 listen
// - Status bit 7 shows CAN transmitter ready
// - Status bit 6 is FD error or invalid
// - Status bit 5 mirrors configuration valid
// - Status bit 4 shows oscillator on target
// - Status bit 3 shows bus silence
// - Partial-networking bits exist only on such variants
// - Status bit 0 shows CAN dominant time-out
// - Status bit 2 shows LIN supply fault
//
// Local design decision: the AXI4-Lite register port.
`default_nettype none
module bus_xcvr_ctrl_status_regs
  import xcvr_regs_pkg::*;
#(
  parameter bit pn_variant   = 1'b1,
  parameter bit dual_lin     = 1'b1
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic [addr_bits-1:0] s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [addr_bits-1:0] s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire xcvr_status_in_t      status_in,
  input  wire logic                 normal_mode,
  input  wire logic                 battery_under_irq,
  input  wire logic                 battery_over_irq,
  output xcvr_ctrl_out_t            ctrl_out
);

  localparam logic [7:0] can_wmask = pn_variant ? can_pn_mask : can_base_mask;
  localparam logic [7:0] lin_wmask = dual_lin ? lin_dual_mask : lin_single_mask;

  function automatic logic mode_is_active(input xcvr_mode_t m);
    mode_is_active = (m == mode_active) || (m == mode_active_b);
  endfunction : mode_is_active

  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic [7:0] mask);
    merge_byte = (old_val & ~mask) | (new_val & mask);
  endfunction : merge_byte

  // Synchronisers for status inputs, normal mode and battery events
  localparam int sync_w = $bits(xcvr_status_in_t) + 3;
  logic [sync_w-1:0] sync1_reg;
  logic [sync_w-1:0] sync2_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {status_in, normal_mode, battery_under_irq, battery_over_irq};
      sync2_reg <= sync1_reg;
    end
  end

  xcvr_status_in_t st_sync;
  logic            normal_sync;
  logic            under_sync;
  logic            over_sync;
  assign {st_sync, normal_sync, under_sync, over_sync} = sync2_reg;

  // Write channel: address and data accepted in either order
  logic                 aw_held_reg;
  logic [addr_bits-1:0] aw_addr_reg;
  logic                 w_held_reg;
  logic [31:0]          w_data_reg;
  logic [3:0]           w_strb_reg;
  logic                 aw_take;
  logic                 w_take;
  logic                 do_write;

  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      s_axi_awready <= !aw_held_reg && !aw_take && !s_axi_awready;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      w_held_reg   <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      s_axi_wready <= !w_held_reg && !w_take && !s_axi_wready;
    end
  end

  logic wr_hit;
  assign wr_hit = (aw_addr_reg == can_ctrl_addr) || (aw_addr_reg == lin_ctrl_addr)
                  || (aw_addr_reg == status_addr);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; only byte lane 0 carries register data
  can_ctrl_t can_ctrl_reg;
  lin_ctrl_t lin_ctrl_reg;
  logic      lane0;
  logic [7:0] can_wr_byte;
  assign lane0 = w_strb_reg[0];
  assign can_wr_byte = merge_byte({1'b0, can_ctrl_reg}, w_data_reg[7:0], can_wmask);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      can_ctrl_reg <= can_ctrl_t'(can_ctrl_reset[6:0]);
    end else if (do_write && lane0 && aw_addr_reg == can_ctrl_addr) begin
      // Bit 7 and non-variant bits keep their zero value
      can_ctrl_reg <= can_ctrl_t'(can_wr_byte[6:0]);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      lin_ctrl_reg <= lin_ctrl_t'(lin_ctrl_reset);
    end else if (do_write && lane0 && aw_addr_reg == lin_ctrl_addr) begin
      lin_ctrl_reg <= lin_ctrl_t'(merge_byte(lin_ctrl_reg, w_data_reg[7:0], lin_wmask));
    end
  end

  // Status byte assembled from synchronised inputs and control state
  logic [7:0] status_byte;
  always_comb begin
    status_byte    = 8'h00;
    status_byte[7] = st_sync.can_tx_ready;
    if (pn_variant) begin
      status_byte[6] = st_sync.fd_frame_error_flag
                       || !can_ctrl_reg.selective_wake_config_valid;
      status_byte[5] = can_ctrl_reg.selective_wake_config_valid;
      status_byte[4] = st_sync.osc_on_target;
    end
    status_byte[3] = st_sync.bus_silence_flag;
    status_byte[2] = st_sync.lin_supply_fault_flag;
    status_byte[1] = st_sync.can_supply_flag;
    status_byte[0] = st_sync.can_tx_timeout_flag;
  end

  // Read channel
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      can_ctrl_addr: rd_byte = {1'b0, can_ctrl_reg};
      lin_ctrl_addr: rd_byte = lin_ctrl_reg;
      status_addr:   rd_byte = status_byte;
      default:       rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_hit ? resp_okay : resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Shut-down latch: set by an enabled battery event in normal mode,
  // released when the policy is set to 00 or normal mode ends
  logic shutdown_reg;
  logic shutdown_hit;
  always_comb begin
    shutdown_hit = 1'b0;
    unique case (can_ctrl_reg.shutdown_policy)
      2'b00: shutdown_hit = 1'b0;
      2'b01: shutdown_hit = under_sync;
      2'b10: shutdown_hit = over_sync;
      2'b11: shutdown_hit = under_sync || over_sync;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      shutdown_reg <= 1'b0;
    end else if (normal_sync && shutdown_hit) begin
      shutdown_reg <= 1'b1;
    end else if (!normal_sync || can_ctrl_reg.shutdown_policy == 2'b00) begin
      shutdown_reg <= 1'b0;
    end
  end

  // Decoded controls to the transceivers, registered
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_out <= '0;
    end else begin
      ctrl_out.can_active <= normal_sync && !shutdown_reg
                             && mode_is_active(can_ctrl_reg.can_xcvr_mode);
      ctrl_out.can_listen <= !shutdown_reg
                             && can_ctrl_reg.can_xcvr_mode == mode_listen;
      ctrl_out.can_supply_uv_enable <= can_ctrl_reg.can_xcvr_mode != mode_active_b;
      ctrl_out.can_shutdown <= shutdown_reg;
      ctrl_out.fd_tolerance_enable <= can_ctrl_reg.fd_tolerance_enable;
      ctrl_out.selective_wake_enable <= can_ctrl_reg.selective_wake_enable
                                        && can_ctrl_reg.selective_wake_config_valid
                                        && !st_sync.fd_frame_error_flag;
      ctrl_out.lin_a_active <= normal_sync && mode_is_active(lin_ctrl_reg.lin_a_mode);
      ctrl_out.lin_a_listen <= lin_ctrl_reg.lin_a_mode == mode_listen;
      ctrl_out.lin_a_timeout_enable <= lin_ctrl_reg.lin_a_slope_sel != slope_no_tout;
      ctrl_out.lin_b_active <= dual_lin && normal_sync
                               && mode_is_active(lin_ctrl_reg.lin_b_mode);
      ctrl_out.lin_b_listen <= dual_lin && lin_ctrl_reg.lin_b_mode == mode_listen;
      ctrl_out.lin_b_timeout_enable <= lin_ctrl_reg.lin_b_slope_sel != slope_no_tout;
    end
  end

endmodule : bus_xcvr_ctrl_status_regs
`default_nettype wire

//--- tb/xcvr_regs_monitor.sv
// Concurrent checks on the transceiver register bank ports.
// Bound into the bank; sees only its read channel and decoded controls.
`default_nettype none
module xcvr_regs_monitor
  import xcvr_regs_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic [addr_bits-1:0] s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire xcvr_ctrl_out_t       ctrl_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic [addr_bits-1:0] rd_addr_reg;
  wire logic            can_rd;
  wire logic            lin_rd;

  // Address of the read now being answered
  always_ff @(posedge clock) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end
  assign can_rd = s_axi_rvalid && (rd_addr_reg == can_ctrl_addr);
  assign lin_rd = s_axi_rvalid && (rd_addr_reg == lin_ctrl_addr);

  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_can_rsvd: assert property (can_rd |-> !s_axi_rdata[7])
    else $error("reserved CAN bit reads one");
  a_unmapped_rd: assert property (s_axi_rvalid && rd_addr_reg != can_ctrl_addr
    && rd_addr_reg != lin_ctrl_addr && rd_addr_reg != status_addr
    |-> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_fd_tol: assert property (can_rd |-> ctrl_out.fd_tolerance_enable == s_axi_rdata[6])
    else $error("fd tolerance output wrong");
  a_can_listen: assert property (can_rd && s_axi_rdata[1:0] == 2'b11
    |-> ctrl_out.can_listen && !ctrl_out.can_active) else $error("CAN listen wrong");
  a_can_uv_off: assert property (can_rd && s_axi_rdata[1:0] == 2'b10
    |-> !ctrl_out.can_supply_uv_enable) else $error("CAN undervoltage not off");
  a_no_shutdown: assert property (can_rd && s_axi_rdata[3:2] == 2'b00
    |-> !ctrl_out.can_shutdown) else $error("CAN shut down with policy off");
  a_lin_tout: assert property (lin_rd && s_axi_rdata[3:2] == 2'b10
    |-> !ctrl_out.lin_a_timeout_enable) else $error("LIN time-out not off");
  a_lin_listen: assert property (lin_rd && s_axi_rdata[1:0] == 2'b11
    |-> ctrl_out.lin_a_listen) else $error("LIN listen wrong");
endmodule : xcvr_regs_monitor

bind bus_xcvr_ctrl_status_regs xcvr_regs_monitor mon_u (
  .clock(clock), .rstn(rstn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .ctrl_out(ctrl_out));
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the transceiver register bank.
// Drives the AXI4-Lite slave and status inputs directly; no partner model.
`default_nettype none
module tb
  import xcvr_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clock, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic                 normal_mode, under_irq, over_irq;
  logic [addr_bits-1:0] awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp;
  xcvr_status_in_t      status_in;
  xcvr_ctrl_out_t       ctrl_out;
  int                   miscompares, checks;

  bus_xcvr_ctrl_status_regs dut_u (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .status_in(status_in), .normal_mode(normal_mode), .battery_under_irq(under_irq),
    .battery_over_irq(over_irq), .ctrl_out(ctrl_out));

  always #5 clock = ~clock;

  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int c);
    repeat (c) @(posedge clock);
  endtask : idle

  task automatic axi_write(input logic [9:0] a, input logic [7:0] d, input logic en,
                           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= {3'b000, en};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bvalid && n < 50) begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      report_and_stop();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axi_write

  task automatic axi_read(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rvalid && n < 50) begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      report_and_stop();
    end
    chk(rdata, {24'h0, d});
    chk({30'h0, rresp}, {30'h0, er});
  endtask : axi_read

  function automatic logic [7:0] stat_exp(input logic [6:0] s, input logic v);
    return {s[6], s[5] | ~v, v, s[4:0]};
  endfunction : stat_exp

  task automatic bus_errors();
    axi_read(can_ctrl_addr, 8'h00, resp_okay);
    axi_read(status_addr, 8'h40, resp_okay);
    axi_write(10'h000, 8'h5a, 1'b1, resp_slverr);
    axi_read(10'h08c, 8'h00, resp_slverr);
    axi_write(lin_ctrl_addr, 8'ha5, 1'b1, resp_okay);
    axi_write(lin_ctrl_addr, 8'h3c, 1'b0, resp_okay);
    axi_read(lin_ctrl_addr, 8'ha5, resp_okay);
    axi_write(status_addr, 8'hff, 1'b1, resp_okay);
    axi_read(status_addr, 8'h40, resp_okay);
    $display("bus_errors done");
  endtask : bus_errors

  task automatic can_fields();
    axi_write(can_ctrl_addr, 8'hff, 1'b1, resp_okay);
    axi_read(can_ctrl_addr, 8'h7f, resp_okay);
    chk({30'h0, ctrl_out.fd_tolerance_enable, ctrl_out.selective_wake_enable}, 32'h3);
    axi_write(can_ctrl_addr, 8'hdf, 1'b1, resp_okay);
    idle(2);
    chk({31'h0, ctrl_out.selective_wake_enable}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      axi_write(can_ctrl_addr, {6'h00, m[1:0]}, 1'b1, resp_okay);
      axi_read(can_ctrl_addr, {6'h00, m[1:0]}, resp_okay);
      chk({29'h0, ctrl_out.can_active, ctrl_out.can_listen, ctrl_out.can_supply_uv_enable},
          {29'h0, m == 1 || m == 2, m == 3, m != 2});
    end
    $display("can_fields done");
  endtask : can_fields

  task automatic lin_fields();
    logic act;
    for (int i = 0; i < 4; i++) begin
      act = (i == 1 || i == 2);
      // Dual-LIN build: bits 7:4 are live, so software may set them
      axi_write(lin_ctrl_addr, {4{i[1:0]}}, 1'b1, resp_okay);
      axi_read(lin_ctrl_addr, {4{i[1:0]}}, resp_okay);
      chk({28'h0, ctrl_out.lin_a_active, ctrl_out.lin_a_listen, ctrl_out.lin_b_active,
           ctrl_out.lin_b_listen}, {28'h0, act, i == 3, act, i == 3});
      if (i < 3) chk({30'h0, ctrl_out.lin_a_timeout_enable, ctrl_out.lin_b_timeout_enable},
                     {30'h0, i != 2, i != 2});
    end
    $display("lin_fields done");
  endtask : lin_fields

  task automatic shutdown_check();
    for (int p = 0; p < 4; p++) begin
      axi_write(can_ctrl_addr, {4'h0, p[1:0], 2'b01}, 1'b1, resp_okay);
      under_irq <= 1'b1;
      idle(4);
      under_irq <= 1'b0;
      idle(2);
      chk({31'h0, ctrl_out.can_shutdown}, {31'h0, p[0]});
      axi_write(can_ctrl_addr, 8'h01, 1'b1, resp_okay);
      idle(2);
      chk({31'h0, ctrl_out.can_shutdown}, 32'h0);
      axi_write(can_ctrl_addr, {4'h0, p[1:0], 2'b01}, 1'b1, resp_okay);
      over_irq <= 1'b1;
      idle(4);
      over_irq <= 1'b0;
      idle(2);
      chk({31'h0, ctrl_out.can_shutdown}, {31'h0, p[1]});
      axi_write(can_ctrl_addr, 8'h01, 1'b1, resp_okay);
    end
    // Outside normal mode a battery event must not shut CAN down
    normal_mode <= 1'b0;
    axi_write(can_ctrl_addr, 8'h0d, 1'b1, resp_okay);
    under_irq <= 1'b1;
    idle(4);
    under_irq <= 1'b0;
    idle(2);
    chk({30'h0, ctrl_out.can_shutdown, ctrl_out.can_active}, 32'h0);
    normal_mode <= 1'b1;
    axi_write(can_ctrl_addr, 8'h01, 1'b1, resp_okay);
    $display("shutdown_check done");
  endtask : shutdown_check

  task automatic status_bits();
    logic [6:0] pats [4] = '{7'h7f, 7'h00, 7'h55, 7'h2a};
    for (int i = 0; i < 4; i++) begin
      status_in <= pats[i];
      axi_write(can_ctrl_addr, {2'b00, i != 2, 5'h00}, 1'b1, resp_okay);
      idle(4);
      axi_read(status_addr, stat_exp(pats[i], i != 2),
               resp_okay);
    end
    $display("status_bits done");
  endtask : status_bits

  initial begin
    {clock, rstn, awvalid, wvalid, bready, arvalid, rready, under_irq, over_irq} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    status_in = '0;
    normal_mode = 1'b1;
    miscompares = 0;
    checks = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    idle(2);
    bus_errors();
    can_fields();
    lin_fields();
    shutdown_check();
    status_bits();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
